/* File: rtl/rpp_core.sv */
`timescale 1ns/10ps
// Contract
// RULE1 - Software sets pin output latch to one
// RULE2 - Plain interrupt use needs source not 11
// RULE3 - Noise canceller drops pulses below threshold
// RULE4 - Each filter code sets accepted width
// RULE5 - Start bit runs counter on count clock
// RULE6 - Measurement captures, clears counter, interrupts
// RULE7 - Overflow at FFH: interrupt, flag, clear
// RULE8 - Software restarts counter after overflow
// RULE9 - Writing start clears overflow flag
// RULE10 - Bit is one when upper nibble reaches threshold
// RULE11 - Byte mode interrupts after eight bits
// RULE12 - Byte mode stores counter per bit
// RULE13 - Bits shift in on active edge
// RULE14 - Bit tally restarts at one after interrupt
// RULE15 - Count clock select gives four resolutions
// RULE16 - Source select picks edge or byte events
// RULE17 - Status shows filtered level and compare
module rpp_core #(
   parameter int unsigned NF_CUT = 0   // Lowers filter exponents to speed simulation
) (
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire logic [11:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [7:0]  rdata_o,
   input  wire logic        remote_wave_in_i,
   output logic             irq_o
);

   // Filter exponent per noise code; zero means bypass
   function automatic int nf_exp(input logic [2:0] code);
      case (code)
         3'h1:    nf_exp = 5;
         3'h2:    nf_exp = 8;
         3'h3:    nf_exp = 9;
         3'h4:    nf_exp = 10;
         3'h5:    nf_exp = 11;
         3'h6:    nf_exp = 13;
         3'h7:    nf_exp = 14;
         default: nf_exp = 0;
      endcase
   endfunction : nf_exp
   // Address match on a strobe
   function automatic logic hit(input logic stb, input logic [11:0] a, input logic [11:0] ofs);
      hit = stb && (a == ofs);
   endfunction : hit
   rpp_pkg::rpp_ctl_one_t ctl1;        // Stored control one
   rpp_pkg::rpp_ctl_one_t next_ctl1;
   rpp_pkg::rpp_ctl_two_t ctl2;        // Stored control two
   rpp_pkg::rpp_ctl_two_t next_ctl2;
   logic [2:0]            sync;        // Pin synchroniser chain
   logic                  stable;      // Level once stages two and three agree
   logic                  next_stable;
   logic [14:0]           nf_cnt;      // Steady-time counter of the canceller
   logic [14:0]           next_nf_cnt;
   logic [14:0]           nf_lim;      // Cycles a new level must hold
   logic                  filt;        // filtered_level_monitor
   logic                  next_filt;
   logic                  lvl_d;       // Polarity-adjusted level, one cycle old
   logic [11:0]           pre;         // Free-running count clock prescaler
   logic [11:0]           pre_mask;
   logic                  tick;        // One count clock period elapsed
   logic [7:0]            cnt;         // The 8-bit up counter
   logic [7:0]            next_cnt;
   logic                  run;         // Counter enabled
   logic                  next_run;
   logic                  ovf;         // counter_overflow_flag
   logic                  next_ovf;
   logic [7:0]            cap;         // interval_count_capture
   logic [7:0]            next_cap;
   logic [7:0]            rbuf;        // decoded_byte_buffer
   logic [7:0]            next_rbuf;
   logic [3:0]            tally;       // received_bit_tally
   logic [3:0]            next_tally;
   logic [2:0]            sts;         // Sticky event status
   logic [2:0]            next_sts;
   logic [2:0]            en;          // Event enable
   logic [2:0]            next_en;
   logic [2:0]            ev;          // Events of this cycle
   logic [7:0]            next_rdata;
   logic                  lvl;         // Filtered level after polarity
   logic                  rise;
   logic                  fall;
   logic                  byte_mode;
   logic                  meas_ev;     // Edge that ends a measurement
   logic                  width_clr;   // Opposite edge in width mode
   logic                  start;       // Write of one to counter_start_bit
   logic                  bit_val;     // Decoded bit, also threshold_compare_monitor

   // Control strobes and derived terms
   always_comb
   begin
      start     = hit(wr_i, addr_i, rpp_pkg::OFS_CTRL_ONE) && wdata_i[rpp_pkg::START_BIT];
      byte_mode = (ctl1.irq_source_select == rpp_pkg::SRC_BYTE); // RULE16
      lvl       = filt ^ ctl2.input_polarity_select;
      rise      = lvl && !lvl_d;
      fall      = !lvl && lvl_d;
      // Active edge in byte mode is the polarity-adjusted rise
      case (ctl1.irq_source_select) // RULE16
         rpp_pkg::SRC_RISE: meas_ev = rise;
         rpp_pkg::SRC_FALL: meas_ev = fall;
         rpp_pkg::SRC_BOTH: meas_ev = rise || fall;
         default:           meas_ev = rise; // RULE13
      endcase
      // Width mode restarts on the other edge so only pulse width counts
      width_clr = ctl1.measure_mode_select && !byte_mode &&
                  (rise || fall) && !meas_ev;
      bit_val   = (cnt[7:4] >= ctl2.bit_decision_threshold); // RULE10 RULE17
   end

   // Synchroniser and noise canceller next state
   always_comb
   begin
      next_stable = (sync[1] == sync[2]) ? sync[2] : stable;
      // A cut larger than the exponent leaves a one-cycle window
      if (nf_exp(ctl1.noise_filter_code) > int'(NF_CUT))
         nf_lim = 15'(15'h1 << (nf_exp(ctl1.noise_filter_code) - int'(NF_CUT)));
      else
         nf_lim = 15'h1;
      next_filt   = filt;
      next_nf_cnt = 15'h0;
      if (ctl1.noise_filter_code == 3'h0)
         next_filt = stable;
      else if (stable != filt)
      begin
         // Short pulses reset the count before it reaches the limit
         if (nf_cnt == nf_lim - 15'h1) // RULE3 RULE4
            next_filt = stable;
         else
            next_nf_cnt = nf_cnt + 15'h1;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         sync   <= 3'h0;
         stable <= 1'b0;
         nf_cnt <= 15'h0;
         filt   <= 1'b0;
         lvl_d  <= 1'b0;
      end
      else
      begin
         sync   <= {sync[1:0], remote_wave_in_i};
         stable <= next_stable;
         nf_cnt <= next_nf_cnt;
         filt   <= next_filt;
         lvl_d  <= lvl;
      end
   end

   // Count clock prescaler; the counter is one free divider, not a gated clock
   always_comb
   begin
      pre_mask = 12'((13'h1 << (rpp_pkg::PRE_BASE_EXP +
                 2 * int'(ctl2.count_clock_select))) - 13'h1); // RULE15
      tick     = ((pre & pre_mask) == pre_mask);
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         pre <= 12'h0;
      else
         pre <= pre + 12'h1;
   end

   // Counter, capture and byte assembly next state
   always_comb
   begin
      next_cnt   = cnt;
      next_run   = run;
      next_ovf   = ovf;
      next_cap   = cap;
      next_rbuf  = rbuf;
      next_tally = tally;
      ev         = 3'h0;
      // Start restarts from zero and drops the old flag
      if (start)
      begin
         next_run   = 1'b1; // RULE5
         next_cnt   = 8'h00;
         next_ovf   = 1'b0; // RULE9
         next_tally = rpp_pkg::RST_TALLY;
      end
      if (run)
      begin
         if (meas_ev)
         begin
            next_cap = cnt; // RULE6 RULE12
            next_cnt = 8'h00;
            if (byte_mode)
            begin
               next_rbuf  = {rbuf[6:0], bit_val}; // RULE13
               next_tally = (tally == rpp_pkg::TALLY_FULL) ? 4'h1 : tally + 4'h1; // RULE14
               ev[rpp_pkg::EV_BYTE] = (next_tally == rpp_pkg::TALLY_FULL); // RULE11
            end
            else
               ev[rpp_pkg::EV_EDGE] = 1'b1; // RULE6
         end
         else if (width_clr)
            next_cnt = 8'h00;
         else if (tick)
         begin
            // Overflow wins over a same-cycle start: the flag is set and run clears
            if (cnt == rpp_pkg::CNT_TOP)
            begin
               next_ovf = 1'b1; // RULE7
               next_cnt = 8'h00;
               next_run = 1'b0; // RULE8
               ev[rpp_pkg::EV_OVF] = 1'b1;
            end
            else if (!start) // A same-cycle start keeps its zero
               next_cnt = cnt + 8'h01; // RULE5
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cnt   <= rpp_pkg::RST_BYTE;
         run   <= 1'b0;
         ovf   <= 1'b0;
         cap   <= rpp_pkg::RST_BYTE;
         rbuf  <= rpp_pkg::RST_BYTE;
         tally <= rpp_pkg::RST_TALLY;
      end
      else
      begin
         cnt   <= next_cnt;
         run   <= next_run;
         ovf   <= next_ovf;
         cap   <= next_cap;
         rbuf  <= next_rbuf;
         tally <= next_tally;
      end
   end

   // Register file, interrupt status and read data
   always_comb
   begin
      next_ctl1 = ctl1;
      next_ctl2 = ctl2;
      next_en   = en;
      next_sts  = sts;
      if (hit(wr_i, addr_i, rpp_pkg::OFS_CTRL_ONE))
         next_ctl1 = {wdata_i[rpp_pkg::NF_LSB +: 3], wdata_i[rpp_pkg::MODE_BIT],
                      wdata_i[rpp_pkg::SRC_LSB +: 2]};
      if (hit(wr_i, addr_i, rpp_pkg::OFS_CTRL_TWO))
         next_ctl2 = {wdata_i[rpp_pkg::THR_LSB +: 4], wdata_i[rpp_pkg::POL_BIT],
                      wdata_i[rpp_pkg::CCK_LSB +: 2]};
      if (hit(wr_i, addr_i, rpp_pkg::OFS_EV_EN))
         next_en = wdata_i[2:0];
      // Set wins over clear so no event is lost
      if (hit(wr_i, addr_i, rpp_pkg::OFS_EV_CLR))
         next_sts = sts & ~wdata_i[2:0];
      next_sts = next_sts | ev;
      // Unmapped and write-only addresses read zero
      next_rdata = 8'h00;
      if (rd_i)
      begin
         case (addr_i)
            rpp_pkg::OFS_CTRL_ONE: next_rdata = {1'b0, ctl1.noise_filter_code, 1'b0,
                                                 ctl1.measure_mode_select, ctl1.irq_source_select};
            rpp_pkg::OFS_CTRL_TWO: next_rdata = {ctl2.bit_decision_threshold, 1'b0,
                                                 ctl2.input_polarity_select,
                                                 ctl2.count_clock_select};
            rpp_pkg::OFS_CAPTURE:  next_rdata = cap;
            rpp_pkg::OFS_BUFFER:   next_rdata = rbuf;
            rpp_pkg::OFS_STATE:    next_rdata = {tally, 1'b0, ovf, bit_val, filt}; // RULE17
            rpp_pkg::OFS_EV_STAT:  next_rdata = {5'h00, sts};
            rpp_pkg::OFS_EV_EN:    next_rdata = {5'h00, en};
            default:               next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         ctl1    <= '0;
         ctl2    <= '0;
         en      <= 3'h0;
         sts     <= 3'h0;
         rdata_o <= rpp_pkg::RST_BYTE;
      end
      else
      begin
         ctl1    <= next_ctl1;
         ctl2    <= next_ctl2;
         en      <= next_en;
         sts     <= next_sts;
         rdata_o <= next_rdata;
      end
   end

   // Level interrupt while any enabled event is pending
   assign irq_o = |(sts & en);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   cap_on_event_a: assert property ( // RULE6
      run && meas_ev && !start |=> cap == $past(cnt) && cnt == 8'h00)
      else $error("Capture or clear missing after measurement");
   edge_irq_a: assert property (run && meas_ev && !byte_mode |=> sts[rpp_pkg::EV_EDGE]) // RULE6
      else $error("Measurement event not flagged");
   ovf_set_a: assert property ( // RULE7
      run && !meas_ev && !width_clr && tick && cnt == 8'hff
      |=> ovf && !run && cnt == 8'h00 && sts[rpp_pkg::EV_OVF])
      else $error("Overflow not handled");
   start_clear_a: assert property ( // RULE9
      start && !(run && !meas_ev && !width_clr && tick && cnt == 8'hff)
      |=> !ovf && run && cnt == 8'h00)
      else $error("Start did not clear flag");
   count_up_a: assert property ( // RULE5
      run && tick && !meas_ev && !width_clr && !start && cnt != 8'hff
      |=> cnt == $past(cnt) + 8'h01)
      else $error("Counter did not advance");
   bit_shift_a: assert property ( // RULE10
      run && byte_mode && meas_ev && !start
      |=> rbuf[0] == ($past(cnt[7:4]) >= $past(ctl2.bit_decision_threshold))
          && rbuf[7:1] == $past(rbuf[6:0]))
      else $error("Decoded bit wrong");
   byte_irq_a: assert property ($rose(sts[rpp_pkg::EV_BYTE]) |-> tally == 4'h8) // RULE11
      else $error("Byte event before eight bits");
   tally_one_a: assert property ( // RULE14
      run && byte_mode && meas_ev && !start && tally == 4'h8 |=> tally == 4'h1)
      else $error("Tally did not restart at one");
   filt_hold_a: assert property ( // RULE3
      $changed(filt) && $past(ctl1.noise_filter_code) != 3'h0
      |-> $past(nf_cnt) == $past(nf_lim) - 15'h1)
      else $error("Filter passed a short pulse");
endmodule : rpp_core

/* File: rtl/rpp_pkg.sv */
package rpp_pkg;

   // Register byte addresses
   localparam logic [11:0] OFS_CTRL_ONE = 12'hfe8;   // receiver_control_one
   localparam logic [11:0] OFS_CTRL_TWO = 12'hfe9;   // receiver_control_two
   localparam logic [11:0] OFS_CAPTURE  = 12'hfea;   // interval_count_capture
   localparam logic [11:0] OFS_BUFFER   = 12'hfeb;   // decoded_byte_buffer
   localparam logic [11:0] OFS_STATE    = 12'hfec;   // receiver_state
   localparam logic [11:0] OFS_EV_STAT  = 12'hfed;   // Sticky event status, read only
   localparam logic [11:0] OFS_EV_CLR   = 12'hfee;   // Event clear, write only
   localparam logic [11:0] OFS_EV_EN    = 12'hfef;   // Event enable

   // Field positions in receiver_control_one
   localparam int SRC_LSB   = 0;   // irq_source_select [1:0]
   localparam int MODE_BIT  = 2;   // measure_mode_select
   localparam int START_BIT = 3;   // counter_start_bit, write only
   localparam int NF_LSB    = 4;   // noise_filter_code [6:4]

   // Field positions in receiver_control_two
   localparam int CCK_LSB  = 0;   // count_clock_select [1:0]
   localparam int POL_BIT  = 2;   // input_polarity_select
   localparam int THR_LSB  = 4;   // bit_decision_threshold [7:4]

   // Event bits in status, clear and enable
   localparam int EV_EDGE = 0;   // Measurement completed
   localparam int EV_OVF  = 1;   // Counter overflow
   localparam int EV_BYTE = 2;   // Eight bits received

   // Interrupt source codes
   localparam logic [1:0] SRC_RISE = 2'h0;
   localparam logic [1:0] SRC_FALL = 2'h1;
   localparam logic [1:0] SRC_BOTH = 2'h2;
   localparam logic [1:0] SRC_BYTE = 2'h3;

   // Reset values, full tally and counter top
   localparam logic [7:0] RST_BYTE   = 8'h00;
   localparam logic [3:0] RST_TALLY  = 4'h0;
   localparam logic [3:0] TALLY_FULL = 4'h8;
   localparam logic [7:0] CNT_TOP    = 8'hff;

   // Count clock: fc/64 times 4 per select step (4 us at 16 MHz for code 0)
   localparam int PRE_BASE_EXP = 6;
   localparam int PRE_WIDTH    = 12;

   // Noise canceller: accept after 2**exp cycles of a steady new level
   localparam int NF_WIDTH = 15;

   // Control fields as carried between processes
   typedef struct packed {
      logic [2:0] noise_filter_code;
      logic       measure_mode_select;
      logic [1:0] irq_source_select;
   } rpp_ctl_one_t;

   typedef struct packed {
      logic [3:0] bit_decision_threshold;
      logic       input_polarity_select;
      logic [1:0] count_clock_select;
   } rpp_ctl_two_t;

endpackage : rpp_pkg

/* File: tb/rpp_wave_model.sv */
`timescale 1ns/10ps
// Receiver that strips the carrier and drives the shared pin
module rpp_wave_model (
   input  wire logic clk_i,   // System clock, paces the levels
   output logic      wave_o   // Demodulated waveform
);
   // Idle low; the receiver always drives, so the pin never floats
   initial wave_o = 1'b0;

   // Drive a level for n cycles; one assignment per call
   task automatic hold(input logic v, input int n);
      wave_o <= v;
      repeat (n) @(posedge clk_i);
   endtask : hold
endmodule : rpp_wave_model

/* File: tb/rpp_core_bench.sv */
`timescale 1ns/10ps
// Self-checking bench for the remote pulse preprocessor
module rpp_core_bench;
   logic        clk_i   = 1'b0;    // 20 MHz system clock
   logic        rstn_i  = 1'b0;    // Held low at start
   logic [11:0] addr_i  = 12'h000; // Register address
   logic [7:0]  wdata_i = 8'h00;   // Write data
   logic        wr_i    = 1'b0;    // Write strobe
   logic        rd_i    = 1'b0;    // Read strobe
   logic [7:0]  rdata_o;           // Read data
   logic        irq_o;             // Interrupt level
   logic        pin;               // Shared pin level
   logic [7:0]  d;                 // Last value read
   int          fails   = 0;       // Mismatches
   int          n_tests = 0;       // Comparisons
   int          cyc     = 0;       // Cycle count for the hang guard

   // Half period of 25 ns
   always #25 clk_i = ~clk_i;

   // Short filter exponents keep the run brief (code 7 -> 32 cycles)
   rpp_core #(.NF_CUT(9)) i_rpp_core (
      .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .remote_wave_in_i(pin), .irq_o(irq_o));

   // Receiver drives the pin; port latch assumed at one
   rpp_wave_model i_rpp_wave_model (.clk_i(clk_i), .wave_o(pin));

   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : final_report

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // One-cycle write strobe
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge clk_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= v;
      @(posedge clk_i);
      wr_i    <= 1'b0;
   endtask : wr

   // Data stands only in the cycle after the strobe; sampled mid-cycle
   task automatic rd(input logic [11:0] a);
      @(posedge clk_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      @(negedge clk_i);
      d = rdata_o;
   endtask : rd

   task automatic rc(input logic [11:0] a, input logic [7:0] exp);
      rd(a);
      chk(d, exp);
   endtask : rc

   // Irq is looked at once register updates have landed
   task automatic ci(input logic e);
      @(negedge clk_i);
      chk({7'h00, irq_o}, {7'h00, e});
   endtask : ci

   task automatic pw(input logic v, input int n);
      i_rpp_wave_model.hold(v, n);
   endtask : pw

   // Reset values, read-only places and unmapped reads
   task automatic t_reset;
      rc(rpp_pkg::OFS_CAPTURE, 8'h00);
      rc(rpp_pkg::OFS_BUFFER, 8'h00);
      rd(rpp_pkg::OFS_STATE);
      chk(d & 8'hfd, 8'h00);
      rc(12'h000, 8'h00);
      rc(rpp_pkg::OFS_EV_CLR, 8'h00);
      wr(rpp_pkg::OFS_CAPTURE, 8'h55);
      rc(rpp_pkg::OFS_CAPTURE, 8'h00);
      wr(rpp_pkg::OFS_CTRL_ONE, 8'h7b);
      rc(rpp_pkg::OFS_CTRL_ONE, 8'h73);
      ci(1'b0);
   endtask : t_reset

   // Every edge source, both polarities, with a glitch first
   task automatic t_edges;
      logic [1:0] src [4] = '{rpp_pkg::SRC_RISE, rpp_pkg::SRC_FALL,
                              rpp_pkg::SRC_BOTH, rpp_pkg::SRC_RISE};
      logic       pol [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
      logic       er [4]  = '{1'b1, 1'b0, 1'b1, 1'b0};
      logic       ef [4]  = '{1'b0, 1'b1, 1'b1, 1'b1};
      wr(rpp_pkg::OFS_EV_EN, 8'h01);
      for (int k = 0; k < 4; k++)
      begin
         wr(rpp_pkg::OFS_CTRL_TWO, {5'h00, pol[k], 2'h0});
         wr(rpp_pkg::OFS_CTRL_ONE, {4'h7, 1'b1, 1'b0, src[k]});
         wr(rpp_pkg::OFS_EV_CLR, 8'h07);
         // 20 cycles is below the 32-cycle threshold
         pw(1'b1, 20);
         pw(1'b0, 100);
         rc(rpp_pkg::OFS_EV_STAT, 8'h00);
         pw(1'b1, 100);
         rc(rpp_pkg::OFS_EV_STAT, {7'h00, er[k]});
         ci(er[k]);
         wr(rpp_pkg::OFS_EV_CLR, 8'h07);
         pw(1'b0, 100);
         rc(rpp_pkg::OFS_EV_STAT, {7'h00, ef[k]});
      end
   endtask : t_edges

   // Free run to overflow, masked then unmasked, then restart
   task automatic t_overflow;
      wr(rpp_pkg::OFS_CTRL_TWO, 8'h20);
      wr(rpp_pkg::OFS_EV_EN, 8'h01);
      wr(rpp_pkg::OFS_EV_CLR, 8'h07);
      wr(rpp_pkg::OFS_CTRL_ONE, 8'h78);
      pw(1'b0, 3000);
      rc(rpp_pkg::OFS_STATE, 8'h02);
      pw(1'b0, 14000);
      rc(rpp_pkg::OFS_STATE, 8'h04);
      rc(rpp_pkg::OFS_EV_STAT, 8'h02);
      ci(1'b0);
      wr(rpp_pkg::OFS_EV_EN, 8'h02);
      ci(1'b1);
      wr(rpp_pkg::OFS_EV_CLR, 8'h02);
      ci(1'b0);
      // Counter stays stopped until software starts it again
      wr(rpp_pkg::OFS_CTRL_ONE, 8'h78);
      rc(rpp_pkg::OFS_STATE, 8'h00);
   endtask : t_overflow

   // One 4096-cycle interval at each count clock
   task automatic t_clock;
      int e;
      for (int c = 0; c < 4; c++)
      begin
         e = 4096 >> (6 + 2 * c);
         wr(rpp_pkg::OFS_CTRL_TWO, {6'h00, 2'(c)});
         wr(rpp_pkg::OFS_CTRL_ONE, 8'h78);
         pw(1'b0, 4056);
         pw(1'b1, 100);
         rd(rpp_pkg::OFS_CAPTURE);
         chk(8'(d >= e - 1 && d <= e + 1), 8'h01);
      end
   endtask : t_clock

   // Eight decoded bits, then the ninth restarts the tally
   task automatic t_byte;
      logic [7:0] pat = 8'ha6;
      wr(rpp_pkg::OFS_CTRL_TWO, 8'h20);
      wr(rpp_pkg::OFS_EV_EN, 8'h04);
      wr(rpp_pkg::OFS_CTRL_ONE, 8'h7b);
      wr(rpp_pkg::OFS_EV_CLR, 8'h07);
      // Long gap 40 ticks decodes one, short gap 10 ticks zero
      for (int k = 7; k >= 0; k--)
      begin
         pw(1'b0, pat[k] ? 2460 : 540);
         pw(1'b1, 100);
         if (k == 1)
            rc(rpp_pkg::OFS_EV_STAT, 8'h00);
      end
      rc(rpp_pkg::OFS_BUFFER, 8'ha6);
      rc(rpp_pkg::OFS_EV_STAT, 8'h04);
      ci(1'b1);
      rd(rpp_pkg::OFS_CAPTURE);
      chk(8'(d >= 8'h09 && d <= 8'h0b), 8'h01);
      rd(rpp_pkg::OFS_STATE);
      chk({4'h0, d[7:4]}, 8'h08);
      wr(rpp_pkg::OFS_EV_CLR, 8'h04);
      pw(1'b0, 540);
      pw(1'b1, 100);
      rd(rpp_pkg::OFS_STATE);
      chk({4'h0, d[7:4]}, 8'h01);
      rc(rpp_pkg::OFS_EV_STAT, 8'h00);
      ci(1'b0);
      pw(1'b0, 10);
   endtask : t_byte

   // Width mode with the canceller bypassed: only the low time is captured
   task automatic t_width;
      wr(rpp_pkg::OFS_CTRL_TWO, 8'h00);
      wr(rpp_pkg::OFS_CTRL_ONE, 8'h0c);
      pw(1'b1, 2000);
      // 1280 cycles low is 20 ticks; the high time must not add in
      pw(1'b0, 1280);
      pw(1'b1, 100);
      rd(rpp_pkg::OFS_CAPTURE);
      chk(8'(d >= 8'h13 && d <= 8'h15), 8'h01);
      wr(rpp_pkg::OFS_EV_CLR, 8'h07);
      // With code zero a 20-cycle pulse is no longer dropped
      pw(1'b0, 20);
      pw(1'b1, 100);
      rc(rpp_pkg::OFS_EV_STAT, 8'h01);
   endtask : t_width

   // Main sequence
   initial
   begin
      repeat (6) @(posedge clk_i);
      rstn_i <= 1'b1;
      t_reset;
      t_edges;
      t_overflow;
      t_clock;
      t_byte;
      t_width;
      final_report;
   end

   // Hang guard, well above the 52k cycles the tests need
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         fails++;
         final_report;
      end
   end
endmodule : rpp_core_bench
